// *** hw/seep_consts.svh ***
// What this block does
// - host keeps select low 1 us between instructions
// - instruction is nine bits, msb first
// - leading one is the start bit
// - read 10xx, write 01xx, erase 11xx
// - enable 0011, disable 0000, erase-all 0010, write-all 0001
// - one serial clock after select rises
// - serial output driven only during read
// - read sends zero dummy then sixteen bits
// - output bits change on rising serial clock
// - erase and write refused until enabled
// - read works whatever the enable state
// - erase sets addressed word to ones
// - host raises select one period after programming
// - write stores sixteen data bits at address
// - programming lasts while select stays low
// - high voltage only during programming operations
// - erase-all sets all words, needs bulk pin
// - write-all stores pattern into every word
// - write-all ignored while bulk pin low
// - serial clock may idle while programming
// - host holds select low 10 to 30 ms
`ifndef SEEP_CONSTS_SVH
`define SEEP_CONSTS_SVH

`define SEEP_WORDS 16
`define SEEP_ERASED 16'hffff
`define SEEP_INSTR_BITS 9
`define SEEP_DATA_BITS 16

`define SEEP_OP_READ 2'h2
`define SEEP_OP_WRITE 2'h1
`define SEEP_OP_ERASE 2'h3
`define SEEP_OP_GLOBAL 2'h0
`define SEEP_OP_PEN 4'h3
`define SEEP_OP_PDIS 4'h0
`define SEEP_OP_ERASE_ALL_CMD 4'h2
`define SEEP_OP_WRITE_ALL_CMD 4'h1

`define SEEP_CLK_PERIOD_NS 50
`define SEEP_SK_MIN_PERIOD_NS 4000
`define SEEP_SK_HALF_CYC ((`SEEP_SK_MIN_PERIOD_NS / 2 + `SEEP_CLK_PERIOD_NS - 1) / `SEEP_CLK_PERIOD_NS)
`define SEEP_GAP_NS 1000
`define SEEP_GAP_CYC ((`SEEP_GAP_NS + `SEEP_CLK_PERIOD_NS - 1) / `SEEP_CLK_PERIOD_NS)
`define SEEP_PROG_MIN_MS 10
`define SEEP_PROG_MAX_MS 30
`define SEEP_PROG_CYC ((`SEEP_PROG_MIN_MS * 1000000 + `SEEP_CLK_PERIOD_NS - 1) / `SEEP_CLK_PERIOD_NS)

`endif

// *** hw/seep_device.sv ***
`timescale 1ns/1ps
`include "seep_consts.svh"
module seep_device
    import seep_pkg::*;
(
    // link
    seep_link_if.device lnk,
    // control, sampled on the serial clock
    input wire logic sys_rst,
    input wire logic clock_en,
    // bulk programming pin, asynchronous
    input wire logic bulk_program_enable_pin,
    // status
    output logic program_voltage_on,
    output logic programming_enabled
);
    typedef enum logic [2:0] {
        D_IDLE,
        D_CMD,
        D_DATA,
        D_READ,
        D_WAIT_DROP,
        D_PROG,
        D_DONE
    } seep_dstate_t;

    typedef struct packed {
        seep_dstate_t state;
        logic [4:0] cnt;
        logic [7:0] instr;
        logic [15:0] sreg;
        logic prog_en;
        logic hv;
        logic do_bit;
        logic do_en;
        seep_mem_t mem;
    } seep_dev_t;

    seep_dev_t r;
    seep_dev_t next_r;
    logic bulk_sync;
    seep_cmd_t cur_cmd;
    logic [3:0] cur_addr;
    logic [7:0] full_instr;
    seep_cmd_t new_cmd;

    seep_sync u_bulk_sync (
        .clock(lnk.serial_clock_in),
        .sys_rst(sys_rst),
        .clock_en(clock_en),
        .async_in(bulk_program_enable_pin),
        .sync_out(bulk_sync)
    );

    assign cur_cmd = seep_decode(r.instr[7:4]);
    assign cur_addr = r.instr[3:0];
    assign full_instr = {r.instr[6:0], lnk.serial_data_in};
    assign new_cmd = seep_decode(full_instr[7:4]);

    // true when a pending programming command will really change the array
    function automatic logic prog_allowed(input seep_cmd_t c, input logic en,
                                          input logic bulk);
        logic ok;
        ok = 1'b0;
        case (c)
            SEEP_CMD_WRITE: ok = en;
            SEEP_CMD_ERASE: ok = en;
            SEEP_CMD_ERASE_ALL_CMD: ok = en && bulk;
            SEEP_CMD_WRITE_ALL_CMD: ok = en && bulk;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    always_comb begin
        next_r = r;
        if (sys_rst) begin
            next_r.state = D_IDLE;
            next_r.cnt = 5'h00;
            next_r.instr = 8'h00;
            next_r.sreg = 16'h0000;
            next_r.prog_en = 1'b0;
            next_r.hv = 1'b0;
            next_r.do_bit = 1'b0;
            next_r.do_en = 1'b0;
            next_r.mem = {`SEEP_WORDS{`SEEP_ERASED}};
        end else if (!clock_en) begin
            next_r = r;
        end else if (!lnk.chip_select) begin
            // select low: release the line, drop partial input
            next_r.do_en = 1'b0;
            next_r.cnt = 5'h00;
            case (r.state)
                D_WAIT_DROP: begin
                    // array changes at the first edge that sees the drop
                    if (prog_allowed(cur_cmd, r.prog_en, bulk_sync)) begin
                        next_r.hv = 1'b1;
                        next_r.state = D_PROG;
                        case (cur_cmd)
                            SEEP_CMD_ERASE: begin
                                next_r.mem[cur_addr] = `SEEP_ERASED;
                            end
                            SEEP_CMD_WRITE: begin
                                next_r.mem[cur_addr] = r.sreg;
                            end
                            SEEP_CMD_ERASE_ALL_CMD: begin
                                next_r.mem = {`SEEP_WORDS{`SEEP_ERASED}};
                            end
                            SEEP_CMD_WRITE_ALL_CMD: begin
                                next_r.mem = {`SEEP_WORDS{r.sreg}};
                            end
                            default: begin
                                next_r.hv = 1'b0;
                            end
                        endcase
                    end else begin
                        next_r.state = D_IDLE;
                    end
                end
                D_PROG: begin
                    // stays until select rises again; no edges needed meanwhile
                    next_r.state = D_PROG;
                end
                default: begin
                    next_r.state = D_IDLE;
                end
            endcase
        end else begin
            case (r.state)
                D_IDLE: begin
                    if (lnk.serial_data_in) begin
                        next_r.state = D_CMD;
                        next_r.cnt = 5'h00;
                        next_r.instr = 8'h00;
                    end
                end
                D_CMD: begin
                    next_r.instr = full_instr;
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == 5'(`SEEP_INSTR_BITS - 2)) begin
                        next_r.cnt = 5'h00;
                        case (new_cmd)
                            SEEP_CMD_READ: begin
                                // dummy zero goes out with the address edge
                                next_r.sreg = r.mem[full_instr[3:0]];
                                next_r.do_bit = 1'b0;
                                next_r.do_en = 1'b1;
                                next_r.state = D_READ;
                            end
                            SEEP_CMD_WRITE, SEEP_CMD_WRITE_ALL_CMD: begin
                                next_r.state = D_DATA;
                            end
                            SEEP_CMD_ERASE, SEEP_CMD_ERASE_ALL_CMD: begin
                                next_r.state = D_WAIT_DROP;
                            end
                            SEEP_CMD_PEN: begin
                                next_r.prog_en = 1'b1;
                                next_r.state = D_DONE;
                            end
                            default: begin
                                next_r.prog_en = 1'b0;
                                next_r.state = D_DONE;
                            end
                        endcase
                    end
                end
                D_DATA: begin
                    next_r.sreg = {r.sreg[14:0], lnk.serial_data_in};
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == 5'(`SEEP_DATA_BITS - 1)) begin
                        next_r.cnt = 5'h00;
                        next_r.state = D_WAIT_DROP;
                    end
                end
                D_READ: begin
                    if (r.cnt == 5'(`SEEP_DATA_BITS)) begin
                        // all bits shown; line released after the last one
                        next_r.do_en = 1'b0;
                        next_r.state = D_DONE;
                    end else begin
                        next_r.do_bit = r.sreg[15];
                        next_r.sreg = {r.sreg[14:0], 1'b0};
                        next_r.cnt = r.cnt + 5'h01;
                    end
                end
                D_WAIT_DROP: begin
                    next_r.state = D_WAIT_DROP;
                end
                D_PROG: begin
                    // select back high ends the cycle
                    next_r.hv = 1'b0;
                    next_r.state = D_IDLE;
                end
                D_DONE: begin
                    next_r.state = D_DONE;
                end
                default: begin
                    next_r.state = D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge lnk.serial_clock_in) begin
        r <= next_r;
    end

    assign lnk.data_out = r.do_bit;
    assign lnk.data_out_en = r.do_en;
    assign program_voltage_on = r.hv;
    assign programming_enabled = r.prog_en;
endmodule

// *** hw/seep_host.sv ***
`timescale 1ns/1ps
`include "seep_consts.svh"
module seep_host
    import seep_pkg::*;
#(
    parameter int PROG_CYCLES = `SEEP_PROG_CYC
) (
    // clocking
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    // request
    input wire logic req_valid,
    input wire seep_cmd_t req_cmd,
    input wire logic [3:0] req_addr,
    input wire logic [15:0] req_data,
    // answer
    output logic busy,
    output logic done,
    output logic [15:0] read_data,
    // link
    seep_link_if.host lnk
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_SELECT,
        H_SHIFT,
        H_READ,
        H_PROG,
        H_RECOVER
    } seep_hstate_t;

    typedef struct packed {
        seep_hstate_t state;
        logic [5:0] div;
        logic sk;
        logic cs;
        logic di;
        logic [4:0] cnt;
        logic [24:0] bits;
        seep_cmd_t cmd;
        logic [4:0] gap;
        logic [17:0] wait_cnt;
        logic [15:0] rd;
        logic busy;
        logic done;
    } seep_host_t;

    localparam logic [5:0] SK_HALF = 6'(`SEEP_SK_HALF_CYC);
    localparam logic [4:0] GAP_CYC = 5'(`SEEP_GAP_CYC);
    localparam logic [17:0] PROG_LAST = 18'(PROG_CYCLES - 1);

    seep_host_t r;
    seep_host_t next_r;
    logic line_sync;
    logic fall_ev;

    seep_sync u_line_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .clock_en(clock_en),
        .async_in(lnk.serial_data_line),
        .sync_out(line_sync)
    );

    // link signals only move as the serial clock falls
    assign fall_ev = (r.div == SK_HALF - 6'h01) && r.sk;

    always_comb begin
        next_r = r;
        if (sys_rst) begin
            next_r = '0;
            next_r.state = H_IDLE;
            next_r.cmd = SEEP_CMD_PDIS;
        end else if (clock_en) begin
            next_r.done = 1'b0;
            // free running clock; while deselected the device uses it to release the line, return to idle and start programming
            if (r.div == SK_HALF - 6'h01) begin
                next_r.div = 6'h00;
                next_r.sk = !r.sk;
            end else begin
                next_r.div = r.div + 6'h01;
            end
            if (!r.cs && r.gap != GAP_CYC) begin
                next_r.gap = r.gap + 5'h01;
            end
            case (r.state)
                H_IDLE: begin
                    if (!r.busy && req_valid) begin
                        next_r.busy = 1'b1;
                        next_r.cmd = req_cmd;
                        next_r.bits = {1'b1, seep_encode(req_cmd), req_addr, req_data};
                        next_r.cnt = seep_has_data(req_cmd) ? 5'(`SEEP_INSTR_BITS +
                            `SEEP_DATA_BITS - 1) : 5'(`SEEP_INSTR_BITS - 1);
                    end
                    if (r.busy && fall_ev && r.gap == GAP_CYC) begin
                        next_r.cs = 1'b1;
                        next_r.di = 1'b0;
                        next_r.state = H_SELECT;
                    end
                end
                H_SELECT: begin
                    if (fall_ev) begin
                        next_r.di = r.bits[24];
                        next_r.bits = {r.bits[23:0], 1'b0};
                        next_r.state = H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (fall_ev) begin
                        if (r.cnt != 5'h00) begin
                            next_r.di = r.bits[24];
                            next_r.bits = {r.bits[23:0], 1'b0};
                            next_r.cnt = r.cnt - 5'h01;
                        end else begin
                            next_r.di = 1'b0;
                            if (r.cmd == SEEP_CMD_READ) begin
                                // dummy bit is on the line now; skipped
                                next_r.state = H_READ;
                            end else if (seep_is_prog(r.cmd)) begin
                                next_r.cs = 1'b0;
                                next_r.gap = 5'h00;
                                next_r.wait_cnt = 18'h00000;
                                next_r.state = H_PROG;
                            end else begin
                                next_r.cs = 1'b0;
                                next_r.gap = 5'h00;
                                next_r.busy = 1'b0;
                                next_r.done = 1'b1;
                                next_r.state = H_IDLE;
                            end
                        end
                    end
                end
                H_READ: begin
                    if (fall_ev) begin
                        next_r.rd = {r.rd[14:0], line_sync};
                        next_r.cnt = r.cnt + 5'h01;
                        if (r.cnt == 5'(`SEEP_DATA_BITS - 1)) begin
                            next_r.cs = 1'b0;
                            next_r.gap = 5'h00;
                            next_r.cnt = 5'h00;
                            next_r.busy = 1'b0;
                            next_r.done = 1'b1;
                            next_r.state = H_IDLE;
                        end
                    end
                end
                H_PROG: begin
                    // waits the least interval, well under the longest
                    if (r.wait_cnt != PROG_LAST) begin
                        next_r.wait_cnt = r.wait_cnt + 18'h00001;
                    end else if (fall_ev) begin
                        next_r.cs = 1'b1;
                        next_r.state = H_RECOVER;
                    end
                end
                H_RECOVER: begin
                    if (fall_ev) begin
                        next_r.cs = 1'b0;
                        next_r.gap = 5'h00;
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                        next_r.state = H_IDLE;
                    end
                end
                default: begin
                    next_r.state = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        r <= next_r;
    end

    assign lnk.serial_clock_in = r.sk;
    assign lnk.chip_select = r.cs;
    assign lnk.serial_data_in = r.di;
    assign busy = r.busy;
    assign done = r.done;
    assign read_data = r.rd;
endmodule

// *** hw/seep_link_if.sv ***
`timescale 1ns/1ps
interface seep_link_if;
    logic serial_clock_in;
    logic chip_select;
    logic serial_data_in;
    logic data_out;
    logic data_out_en;
    wire serial_data_line;

    // released line shows the inverse, so a late sample reads as bad data
    assign serial_data_line = data_out_en ? data_out : !data_out;

    modport device (
        input serial_clock_in,
        input chip_select,
        input serial_data_in,
        output data_out,
        output data_out_en
    );

    modport host (
        output serial_clock_in,
        output chip_select,
        output serial_data_in,
        input serial_data_line
    );
endinterface

// *** hw/seep_pkg.sv ***
`include "seep_consts.svh"
package seep_pkg;

    typedef enum logic [2:0] {
        SEEP_CMD_READ,
        SEEP_CMD_WRITE,
        SEEP_CMD_ERASE,
        SEEP_CMD_PEN,
        SEEP_CMD_PDIS,
        SEEP_CMD_ERASE_ALL_CMD,
        SEEP_CMD_WRITE_ALL_CMD
    } seep_cmd_t;

    typedef logic [`SEEP_WORDS-1:0][`SEEP_DATA_BITS-1:0] seep_mem_t;

    function automatic seep_cmd_t seep_decode(input logic [3:0] op);
        seep_cmd_t c;
        c = SEEP_CMD_PDIS;
        case (op[3:2])
            `SEEP_OP_READ: c = SEEP_CMD_READ;
            `SEEP_OP_WRITE: c = SEEP_CMD_WRITE;
            `SEEP_OP_ERASE: c = SEEP_CMD_ERASE;
            default: begin
                case (op)
                    `SEEP_OP_PEN: c = SEEP_CMD_PEN;
                    `SEEP_OP_ERASE_ALL_CMD: c = SEEP_CMD_ERASE_ALL_CMD;
                    `SEEP_OP_WRITE_ALL_CMD: c = SEEP_CMD_WRITE_ALL_CMD;
                    default: c = SEEP_CMD_PDIS;
                endcase
            end
        endcase
        return c;
    endfunction

    function automatic logic [3:0] seep_encode(input seep_cmd_t c);
        logic [3:0] op;
        op = `SEEP_OP_PDIS;
        case (c)
            SEEP_CMD_READ: op = {`SEEP_OP_READ, 2'h0};
            SEEP_CMD_WRITE: op = {`SEEP_OP_WRITE, 2'h0};
            SEEP_CMD_ERASE: op = {`SEEP_OP_ERASE, 2'h0};
            SEEP_CMD_PEN: op = `SEEP_OP_PEN;
            SEEP_CMD_ERASE_ALL_CMD: op = `SEEP_OP_ERASE_ALL_CMD;
            SEEP_CMD_WRITE_ALL_CMD: op = `SEEP_OP_WRITE_ALL_CMD;
            default: op = `SEEP_OP_PDIS;
        endcase
        return op;
    endfunction

    function automatic logic seep_is_prog(input seep_cmd_t c);
        return (c == SEEP_CMD_WRITE) || (c == SEEP_CMD_ERASE) ||
               (c == SEEP_CMD_ERASE_ALL_CMD) || (c == SEEP_CMD_WRITE_ALL_CMD);
    endfunction

    function automatic logic seep_has_data(input seep_cmd_t c);
        return (c == SEEP_CMD_WRITE) || (c == SEEP_CMD_WRITE_ALL_CMD);
    endfunction

endpackage

// *** hw/seep_sync.sv ***
`timescale 1ns/1ps
module seep_sync
    import seep_pkg::*;
(
    // clocking
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    // level
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } seep_sync_t;

    seep_sync_t r;
    seep_sync_t next_r;

    always_comb begin
        next_r = r;
        if (sys_rst) begin
            next_r = '0;
        end else if (clock_en) begin
            next_r.stage1 = async_in;
            next_r.stage2 = r.stage1;
        end
    end

    always_ff @(posedge clock) begin
        r <= next_r;
    end

    assign sync_out = r.stage2;
endmodule

// *** tb/seep_link_checker.sv ***
`timescale 1ns/1ps
module seep_link_checker (
    // link
    input wire logic serial_clock_in,
    input wire logic chip_select,
    input wire logic serial_data_in,
    input wire logic data_out,
    input wire logic data_out_en,
    // device side
    input wire logic sys_rst,
    input wire logic program_voltage_on
);
    logic [8:0] instr_bits;
    logic fall_val;
    default clocking @(posedge serial_clock_in); endclocking
    default disable iff (sys_rst);
    // last nine bits under select, so a read can be traced to its opcode
    always_ff @(posedge serial_clock_in) begin
        if (sys_rst || !chip_select) begin
            instr_bits <= 9'h000;
        end else begin
            instr_bits <= {instr_bits[7:0], serial_data_in};
        end
    end
    // output as left at the falling edge; a change there would differ
    always_ff @(negedge serial_clock_in) begin
        fall_val <= data_out;
    end
    out_idle_a: assert property (!chip_select |=> !data_out_en)
        else $error("output still driven after select low");
    dummy_zero_a: assert property ($rose(data_out_en) |-> !data_out)
        else $error("first read bit not zero");
    out_window_a: assert property ($rose(data_out_en) |->
        data_out_en [*8] ##1 data_out_en [*8] ##1 data_out_en ##1 !data_out_en)
        else $error("read output window not seventeen bits");
    read_code_a: assert property ($rose(data_out_en) |-> instr_bits[8:6] == 3'h6)
        else $error("output enabled without a read instruction");
    out_rise_a: assert property (data_out_en |-> data_out == fall_val)
        else $error("output changed on falling edge");
    start_quiet_a: assert property ($rose(chip_select) |-> !serial_data_in)
        else $error("data bit in first clock after select");
    volt_stop_a: assert property (program_voltage_on && chip_select |=> !program_voltage_on)
        else $error("programming voltage stays after select high");
    volt_start_a: assert property ($rose(program_voltage_on) |-> !$past(chip_select))
        else $error("programming started with select high");
    volt_quiet_a: assert property (program_voltage_on |-> !data_out_en)
        else $error("programming voltage during read");
    cover property ($rose(data_out_en));
    cover property ($rose(program_voltage_on));
    cover property ($rose(chip_select));
endmodule

// *** tb/serial_eeprom_instruction_port_bench.sv ***
`timescale 1ns/1ps
module serial_eeprom_instruction_port_bench
    import seep_pkg::*;
;
    typedef struct {
        seep_cmd_t cmd;
        logic [3:0] addr;
        logic [15:0] data;
        logic bulk;
        logic [15:0] exp;
    } seep_row_t;
    `define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
        $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic dev_rst = 1'b1;
    logic req_valid = 1'b0;
    seep_cmd_t req_cmd = SEEP_CMD_READ;
    logic [3:0] req_addr = 4'h0;
    logic [15:0] req_data = 16'h0000;
    logic bulk_pin = 1'b0;
    logic busy, done, prog_volt, prog_en;
    logic [15:0] read_data;
    logic dummy_bit;
    int miscompares = 0;
    int total_checks = 0;
    int en_falls = 0;
    int volt_rises = 0;
    // exp: word read back, or programming pulses for other commands
    // short programming time keeps the run small
    seep_row_t rows [20] = '{
        '{SEEP_CMD_READ, 4'h3, 16'h0000, 1'b0, 16'hffff},
        '{SEEP_CMD_WRITE, 4'h3, 16'h1234, 1'b0, 16'h0000},
        '{SEEP_CMD_READ, 4'h3, 16'h0000, 1'b0, 16'hffff},
        '{SEEP_CMD_PEN, 4'h0, 16'h0000, 1'b0, 16'h0000},
        '{SEEP_CMD_WRITE, 4'h3, 16'ha5c3, 1'b0, 16'h0001},
        '{SEEP_CMD_READ, 4'h3, 16'h0000, 1'b0, 16'ha5c3},
        '{SEEP_CMD_ERASE, 4'h3, 16'h0000, 1'b0, 16'h0001},
        '{SEEP_CMD_READ, 4'h3, 16'h0000, 1'b0, 16'hffff},
        '{SEEP_CMD_WRITE, 4'hf, 16'h0f0f, 1'b0, 16'h0001},
        '{SEEP_CMD_ERASE_ALL_CMD, 4'h0, 16'h0000, 1'b0, 16'h0000},
        '{SEEP_CMD_READ, 4'hf, 16'h0000, 1'b0, 16'h0f0f},
        '{SEEP_CMD_ERASE_ALL_CMD, 4'h0, 16'h0000, 1'b1, 16'h0001},
        '{SEEP_CMD_READ, 4'hf, 16'h0000, 1'b0, 16'hffff},
        '{SEEP_CMD_WRITE_ALL_CMD, 4'h0, 16'h5555, 1'b0, 16'h0000},
        '{SEEP_CMD_READ, 4'h0, 16'h0000, 1'b0, 16'hffff},
        '{SEEP_CMD_WRITE_ALL_CMD, 4'h0, 16'h3c3c, 1'b1, 16'h0001},
        '{SEEP_CMD_READ, 4'h9, 16'h0000, 1'b0, 16'h3c3c},
        '{SEEP_CMD_PDIS, 4'h0, 16'h0000, 1'b0, 16'h0000},
        '{SEEP_CMD_ERASE, 4'h9, 16'h0000, 1'b0, 16'h0000},
        '{SEEP_CMD_READ, 4'h9, 16'h0000, 1'b0, 16'h3c3c}
    };

    seep_link_if lnk ();
    seep_host #(.PROG_CYCLES(50)) i_seep_host (.clock(clock), .sys_rst(sys_rst),
        .clock_en(1'b1), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
        .req_data(req_data), .busy(busy), .done(done), .read_data(read_data), .lnk(lnk));
    seep_device i_seep_device (.lnk(lnk), .sys_rst(dev_rst), .clock_en(1'b1),
        .bulk_program_enable_pin(bulk_pin), .program_voltage_on(prog_volt),
        .programming_enabled(prog_en));
    seep_link_checker i_seep_link_checker (.serial_clock_in(lnk.serial_clock_in),
        .chip_select(lnk.chip_select), .serial_data_in(lnk.serial_data_in),
        .data_out(lnk.data_out), .data_out_en(lnk.data_out_en), .sys_rst(dev_rst),
        .program_voltage_on(prog_volt));

    always #25 clock = ~clock;
    // count falling edges that see the line driven, and catch the first bit
    always @(negedge lnk.serial_clock_in) begin
        if (lnk.data_out_en === 1'b1) begin
            if (en_falls == 0) begin
                dummy_bit = lnk.serial_data_line;
            end
            en_falls++;
        end
    end
    // one pulse per programming operation the device accepted
    always @(posedge prog_volt) begin
        volt_rises++;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // release only just after a fall, far from the rise that samples it
    task automatic set_dev_rst(input logic v);
        @(negedge lnk.serial_clock_in);
        @(posedge clock);
        dev_rst <= v;
    endtask

    task automatic do_op(input seep_cmd_t c, input logic [3:0] a, input logic [15:0] d,
                         input logic b, input logic [15:0] exp);
        int n;
        @(posedge clock);
        en_falls = 0;
        volt_rises = 0;
        bulk_pin <= b;
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        req_data <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        @(posedge clock);
        `CHK(busy, 1'b1)
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (done !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            miscompares++;
            $display("BAD t=%0t no done", $time);
        end
        `CHK(busy, 1'b0)
        if (c == SEEP_CMD_READ) begin
            `CHK(read_data, exp)
            `CHK(en_falls, 17)
            `CHK(dummy_bit, 1'b0)
            `CHK(volt_rises, 0)
        end else begin
            `CHK(en_falls, 0)
            `CHK(volt_rises, exp)
        end
    endtask

    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge lnk.serial_clock_in);
        set_dev_rst(1'b0);
        `CHK(prog_en, 1'b0)
        foreach (rows[i]) begin
            do_op(rows[i].cmd, rows[i].addr, rows[i].data, rows[i].bulk, rows[i].exp);
            $display("row %0d done", i);
        end
        // device reset in mid-run drops the enable again
        do_op(SEEP_CMD_PEN, 4'h0, 16'h0000, 1'b0, 16'h0000);
        `CHK(prog_en, 1'b1)
        set_dev_rst(1'b1);
        repeat (3) @(posedge lnk.serial_clock_in);
        set_dev_rst(1'b0);
        `CHK(prog_en, 1'b0)
        do_op(SEEP_CMD_WRITE, 4'h9, 16'h0000, 1'b0, 16'h0000);
        do_op(SEEP_CMD_READ, 4'h9, 16'h0000, 1'b0, 16'hffff);
        $display("reset test done");
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
endmodule
